// ---- rtl/accel_out_regs.sv ----
// Output register set of a three-axis accelerometer: axis result bytes,
// queue read port and unread count, behind a byte-wide read port.
// Assumes samples and reads come from logic on the same 100 MHz clock.
//
// Functional notes
// (R1) Calibration offsets are fixed constants; no path lets the user change them.
// (R2) Axis bytes: sign, d11..d5 high; d4..d0 low bits 7..3, rest zero.
// (R3) Queue 11-bit form: sign, d9..d3 high; d2..d0 in low bits 7..5.
// (R4) Queue 8-bit form: sign and d6..d0 in high byte only.
// (R5) Wide range: lowest bit weighs 0.75 mg, top bit 1536 mg.
// (R6) Narrow range: lowest bit weighs 0.5 mg, top bit 1024 mg.
// (R7) Queue samples are read through one byte at 0Fh, zero after reset.
// (R8) Six axis bytes, low then high for X, Y, Z, zero after reset.
// (R9) Register 15h reports how many queued samples are still unread.
// (R10) Reader treats sign and data bits together as two's complement.
module accel_out_regs #(
  parameter bit NARROW_RANGE = 1'b0 // Set for the narrow-range variant
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic sample_valid, // One-cycle pulse: new raw sample on the axis inputs
  input wire logic [12:0] x_raw, // X raw sample, two's complement
  input wire logic [12:0] y_raw, // Y raw sample, two's complement
  input wire logic [12:0] z_raw, // Z raw sample, two's complement
  input wire logic queue_enable, // Level: store samples into the queue
  input wire logic queue_8bit, // Level: 8-bit queue form instead of 11-bit
  input wire logic rd_en, // One-cycle read strobe
  input wire logic [5:0] rd_addr, // Register address of the read
  output logic [7:0] rd_data, // Read answer, one cycle after the strobe
  output logic rd_valid, // Marks rd_data as fresh
  output logic [15:0] lsb_weight_ug, // Weight of the lowest result bit, micro-g
  output logic [15:0] top_weight_mg // Weight of the top data bit, mg
);

  // Calibrated axis samples backing the result bytes
  logic [12:0] cal_x_r;
  logic [12:0] cal_y_r;
  logic [12:0] cal_z_r;
  logic [12:0] cal_x_nxt;
  logic [12:0] cal_y_nxt;
  logic [12:0] cal_z_nxt;
  accel_out_pkg::push_state_t push_state_r;
  accel_out_pkg::push_state_t push_state_nxt;
  logic half_r;
  logic half_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;
  logic [15:0] lsb_weight_r;
  logic [15:0] top_weight_r;

  // Packed forms of each axis
  logic [7:0] x_hi;
  logic [7:0] x_lo;
  logic [7:0] x_b11_lo;
  logic [7:0] x_b8_hi;
  logic [7:0] y_hi;
  logic [7:0] y_lo;
  logic [7:0] y_b11_lo;
  logic [7:0] y_b8_hi;
  logic [7:0] z_hi;
  logic [7:0] z_lo;
  logic [7:0] z_b11_lo;
  logic [7:0] z_b8_hi;

  // Queue signals
  logic [15:0] q_head;
  logic [accel_out_pkg::QCOUNT_W-1:0] q_count;
  logic q_empty;
  logic q_full;

  // Offsets live only in constants; a wrap on overflow is accepted
  function automatic logic [12:0] add_offset(input logic [12:0] raw, input logic [12:0] offs);
    add_offset = raw + offs;
  endfunction

  // One entry of the queue in the selected form
  function automatic logic [15:0] queue_entry(input logic mode8, input logic [7:0] hi, input logic [7:0] lo11,
                                              input logic [7:0] hi8);
    queue_entry = mode8 ? {hi8, 8'h00} : {hi, lo11};
  endfunction

  accel_byte_pack u_pack_x (
    .value(cal_x_r),
    .full_hi(x_hi),
    .full_lo(x_lo),
    .buf11_lo(x_b11_lo),
    .buf8_hi(x_b8_hi)
  );

  accel_byte_pack u_pack_y (
    .value(cal_y_r),
    .full_hi(y_hi),
    .full_lo(y_lo),
    .buf11_lo(y_b11_lo),
    .buf8_hi(y_b8_hi)
  );

  accel_byte_pack u_pack_z (
    .value(cal_z_r),
    .full_hi(z_hi),
    .full_lo(z_lo),
    .buf11_lo(z_b11_lo),
    .buf8_hi(z_b8_hi)
  );

  // Address decode of the read port
  wire hit_x_lo = (rd_addr == accel_out_pkg::X_LOW_ADDR);
  wire hit_x_hi = (rd_addr == accel_out_pkg::X_HIGH_ADDR);
  wire hit_y_lo = (rd_addr == accel_out_pkg::Y_LOW_ADDR);
  wire hit_y_hi = (rd_addr == accel_out_pkg::Y_HIGH_ADDR);
  wire hit_z_lo = (rd_addr == accel_out_pkg::Z_LOW_ADDR);
  wire hit_z_hi = (rd_addr == accel_out_pkg::Z_HIGH_ADDR);
  wire hit_queue = (rd_addr == accel_out_pkg::QUEUE_PORT_ADDR);
  wire hit_count = (rd_addr == accel_out_pkg::QUEUE_COUNT_ADDR);
  wire queue_read = rd_en && hit_queue && !q_empty;
  // In 11-bit form the low byte is the second read, which retires the entry
  wire queue_pop = queue_read && (queue_8bit || half_r); // [R3] [R4]
  wire [7:0] queue_byte = q_empty ? accel_out_pkg::REG_RESET :
                          (queue_8bit || !half_r) ? q_head[15:8] : q_head[7:0]; // [R7]
  wire [7:0] count_byte = {2'h0, q_count}; // [R9]

  // Push sequencing: X, then Y, then Z from the latched sample
  wire q_push = (push_state_r != accel_out_pkg::PUSH_IDLE);
  wire [15:0] push_word = (push_state_r == accel_out_pkg::PUSH_X) ? queue_entry(queue_8bit, x_hi, x_b11_lo, x_b8_hi) :
                          (push_state_r == accel_out_pkg::PUSH_Y) ? queue_entry(queue_8bit, y_hi, y_b11_lo, y_b8_hi) :
                          queue_entry(queue_8bit, z_hi, z_b11_lo, z_b8_hi);

  sample_ring u_ring (
    .clk(clk),
    .reset_n(reset_n),
    .push(q_push),
    .push_data(push_word),
    .pop(queue_pop),
    .head_data(q_head),
    .count(q_count),
    .empty(q_empty),
    .full(q_full)
  );

  // Calibration applied as each raw sample arrives
  always_comb begin
    cal_x_nxt = cal_x_r;
    cal_y_nxt = cal_y_r;
    cal_z_nxt = cal_z_r;
    if (sample_valid) begin
      cal_x_nxt = add_offset(x_raw, accel_out_pkg::NV_X_OFFSET); // [R1]
      cal_y_nxt = add_offset(y_raw, accel_out_pkg::NV_Y_OFFSET); // [R1]
      cal_z_nxt = add_offset(z_raw, accel_out_pkg::NV_Z_OFFSET); // [R1]
    end
  end

  // A new sample with queue_enable set restarts the sequence at X; entries of the old sample already pushed stay queued
  always_comb begin
    push_state_nxt = push_state_r;
    unique case (push_state_r)
      accel_out_pkg::PUSH_IDLE: push_state_nxt = accel_out_pkg::PUSH_IDLE;
      accel_out_pkg::PUSH_X: push_state_nxt = accel_out_pkg::PUSH_Y;
      accel_out_pkg::PUSH_Y: push_state_nxt = accel_out_pkg::PUSH_Z;
      accel_out_pkg::PUSH_Z: push_state_nxt = accel_out_pkg::PUSH_IDLE;
    endcase
    if (sample_valid && queue_enable) begin
      push_state_nxt = accel_out_pkg::PUSH_X;
    end
  end

  // Byte phase of the queue port
  always_comb begin
    half_nxt = half_r;
    if (queue_8bit) begin
      half_nxt = 1'b0;
    end else if (queue_read) begin
      half_nxt = !half_r;
    end
  end

  // Read answer mux; unmapped addresses answer zero
  always_comb begin
    rd_data_nxt = accel_out_pkg::REG_RESET;
    if (hit_x_lo) begin
      rd_data_nxt = x_lo; // [R8]
    end else if (hit_x_hi) begin
      rd_data_nxt = x_hi; // [R8]
    end else if (hit_y_lo) begin
      rd_data_nxt = y_lo; // [R8]
    end else if (hit_y_hi) begin
      rd_data_nxt = y_hi; // [R8]
    end else if (hit_z_lo) begin
      rd_data_nxt = z_lo; // [R8]
    end else if (hit_z_hi) begin
      rd_data_nxt = z_hi; // [R8]
    end else if (hit_queue) begin
      rd_data_nxt = queue_byte; // [R7]
    end else if (hit_count) begin
      rd_data_nxt = count_byte; // [R9]
    end
  end

  // Sample and sequencing state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cal_x_r <= accel_out_pkg::SAMPLE_RESET; // [R8]
      cal_y_r <= accel_out_pkg::SAMPLE_RESET;
      cal_z_r <= accel_out_pkg::SAMPLE_RESET;
      push_state_r <= accel_out_pkg::PUSH_IDLE;
      half_r <= 1'b0;
    end else begin
      cal_x_r <= cal_x_nxt;
      cal_y_r <= cal_y_nxt;
      cal_z_r <= cal_z_nxt;
      push_state_r <= push_state_nxt;
      half_r <= half_nxt;
    end
  end

  // Read port; data holds between reads
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_r <= accel_out_pkg::REG_RESET;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en;
      if (rd_en) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  // Scale of the variant, settled one edge after reset releases
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lsb_weight_r <= accel_out_pkg::WEIGHT_RESET;
      top_weight_r <= accel_out_pkg::WEIGHT_RESET;
    end else begin
      lsb_weight_r <= NARROW_RANGE ? accel_out_pkg::LSB_WEIGHT_NARROW_UG : accel_out_pkg::LSB_WEIGHT_WIDE_UG; // [R5] [R6]
      top_weight_r <= NARROW_RANGE ? accel_out_pkg::TOP_WEIGHT_NARROW_MG : accel_out_pkg::TOP_WEIGHT_WIDE_MG; // [R5] [R6]
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign lsb_weight_ug = lsb_weight_r;
  assign top_weight_mg = top_weight_r;

  // Checks on the packing, the queue port and the read answers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cal_fixed;
    sample_valid |=> cal_x_r == $past(x_raw) + accel_out_pkg::NV_X_OFFSET;
  endproperty
  a_cal_fixed: assert property (p_cal_fixed) else $error("calibration offset not applied"); // [R1]

  property p_axis_low;
    rd_en && (hit_x_lo || hit_y_lo || hit_z_lo) |=> rd_valid && rd_data[2:0] == 3'h0;
  endproperty
  a_axis_low: assert property (p_axis_low) else $error("axis low byte unused bits set"); // [R2]

  property p_axis_high;
    rd_en && hit_y_hi && !sample_valid |=> rd_data == {$past(cal_y_r[12]), $past(cal_y_r[11:5])};
  endproperty
  a_axis_high: assert property (p_axis_high) else $error("axis high byte packing wrong"); // [R2]

  property p_queue11_low;
    queue_pop && !queue_8bit && !$past(queue_8bit) |=> rd_data[4:0] == 5'h00;
  endproperty
  a_queue11_low: assert property (p_queue11_low) else $error("11-bit low byte unused bits set"); // [R3]

  property p_queue8_pop;
    rd_en && hit_queue && queue_8bit && !q_empty && !q_push |=> q_count == $past(q_count) - 1'b1;
  endproperty
  a_queue8_pop: assert property (p_queue8_pop) else $error("8-bit read did not retire entry"); // [R4]

  property p_weights;
    $past(reset_n) |-> 32'(top_weight_mg) * 32'h3E8 == 32'(lsb_weight_ug) * 32'h800;
  endproperty
  a_weights: assert property (p_weights) else $error("bit weights inconsistent"); // [R5] [R6]

  property p_queue_empty;
    rd_en && hit_queue && q_empty |=> rd_data == 8'h00;
  endproperty
  a_queue_empty: assert property (p_queue_empty) else $error("empty queue read not zero"); // [R7]

  property p_reset_zero;
    $rose(reset_n) |-> cal_x_r == 13'h0000 && cal_z_r == 13'h0000 && q_count == 6'h00 && rd_data == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset"); // [R8]

  property p_count_read;
    rd_en && hit_count |=> rd_data == {2'h0, $past(q_count)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("count register wrong"); // [R9]

  property p_push_three;
    sample_valid && queue_enable ##1 !sample_valid [*3] |-> $past(q_push, 2) && $past(q_push) && q_push;
  endproperty
  a_push_three: assert property (p_push_three) else $error("sample not pushed as three axes"); // [R9]

  c_two_reads: cover property (queue_read && !queue_8bit ##[1:8] queue_pop);
  c_byte_read: cover property (queue_pop && queue_8bit);
  c_overwrite: cover property (q_full && q_push && !queue_pop);
  c_count_seen: cover property (rd_en && hit_count && q_count != 6'h00);

endmodule

// ---- rtl/accel_out_pkg.sv ----
// Shared constants of the accelerometer output register block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package accel_out_pkg;

  // Register addresses of the byte-wide read port
  localparam logic [5:0] X_LOW_ADDR = 6'h04;
  localparam logic [5:0] X_HIGH_ADDR = 6'h05;
  localparam logic [5:0] Y_LOW_ADDR = 6'h06;
  localparam logic [5:0] Y_HIGH_ADDR = 6'h07;
  localparam logic [5:0] Z_LOW_ADDR = 6'h08;
  localparam logic [5:0] Z_HIGH_ADDR = 6'h09;
  localparam logic [5:0] QUEUE_PORT_ADDR = 6'h0F;
  localparam logic [5:0] QUEUE_COUNT_ADDR = 6'h15;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [12:0] SAMPLE_RESET = 13'h0000;

  // Field positions inside a 13-bit two's complement sample
  localparam int SIGN_POS = 12;
  localparam int HIGH_FIELD_LSB = 5;
  localparam int BUF11_FIELD_LSB = 2;

  // Sample queue geometry
  localparam int QUEUE_DEPTH = 32;
  localparam int QPTR_W = 5;
  localparam int QCOUNT_W = 6;
  localparam logic [QPTR_W-1:0] QPTR_RESET = 5'h00;
  localparam logic [QCOUNT_W-1:0] QCOUNT_RESET = 6'h00;

  // Factory-programmed calibration offsets per axis
  localparam logic [12:0] NV_X_OFFSET = 13'h0000;
  localparam logic [12:0] NV_Y_OFFSET = 13'h0000;
  localparam logic [12:0] NV_Z_OFFSET = 13'h0000;

  // Scale of a full axis result, in micro-g per lowest bit and mg at the top bit
  localparam logic [15:0] LSB_WEIGHT_WIDE_UG = 16'h02EE;
  localparam logic [15:0] LSB_WEIGHT_NARROW_UG = 16'h01F4;
  localparam logic [15:0] TOP_WEIGHT_WIDE_MG = 16'h0600;
  localparam logic [15:0] TOP_WEIGHT_NARROW_MG = 16'h0400;
  localparam logic [15:0] WEIGHT_RESET = 16'h0000;

  // Order in which one sample's axes enter the queue
  typedef enum logic [1:0] {PUSH_IDLE, PUSH_X, PUSH_Y, PUSH_Z} push_state_t;

endpackage

// ---- rtl/accel_byte_pack.sv ----
// Byte packing of one calibrated axis sample for the result and queue registers.
// Pure combinational; the parent registers whatever leaves the block.
module accel_byte_pack (
  input wire logic [12:0] value, // Two's complement sample, top bit is the sign
  output logic [7:0] full_hi, // High byte of the full result
  output logic [7:0] full_lo, // Low byte of the full result
  output logic [7:0] buf11_lo, // Low byte of the 11-bit queue form
  output logic [7:0] buf8_hi // Only byte of the 8-bit queue form
);

  // Sign then the top seven data bits; every form shares this byte
  assign full_hi = {value[accel_out_pkg::SIGN_POS], value[11:accel_out_pkg::HIGH_FIELD_LSB]}; // [R2] [R3]
  // Five low data bits, bottom three always zero
  assign full_lo = {value[4:0], 3'h0}; // [R2]
  // Queue keeps ten data bits, so three sit in the low byte
  assign buf11_lo = {value[4:accel_out_pkg::BUF11_FIELD_LSB], 5'h00}; // [R3]
  // Eight-bit form drops everything below the high byte
  assign buf8_hi = full_hi; // [R4]

endmodule

// ---- rtl/sample_ring.sv ----
// Ring of packed queue entries held in flip-flops.
// Assumes pushes and pops come from logic on the same clock.
module sample_ring (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic push, // Store one entry this cycle
  input wire logic [15:0] push_data, // Entry: high byte then low byte
  input wire logic pop, // Drop the oldest entry this cycle
  output logic [15:0] head_data, // Oldest entry
  output logic [accel_out_pkg::QCOUNT_W-1:0] count, // Entries not yet read
  output logic empty, // No entry held
  output logic full // Every slot taken
);

  logic [15:0] mem_r [accel_out_pkg::QUEUE_DEPTH];
  logic [accel_out_pkg::QPTR_W-1:0] wr_ptr_r;
  logic [accel_out_pkg::QPTR_W-1:0] rd_ptr_r;
  logic [accel_out_pkg::QCOUNT_W-1:0] count_r;
  wire do_pop = pop && !empty;
  // A push into a full ring drops the oldest entry so the newest are kept
  wire drop_old = push && full && !do_pop;
  wire adv_rd = do_pop || drop_old;

  assign empty = (count_r == accel_out_pkg::QCOUNT_RESET);
  assign full = (count_r == accel_out_pkg::QCOUNT_W'(accel_out_pkg::QUEUE_DEPTH));
  assign head_data = mem_r[rd_ptr_r];
  assign count = count_r;

  // Entry storage, no reset needed since count guards the reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= push_data;
    end
  end

  // Pointers and the unread count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_r <= accel_out_pkg::QPTR_RESET;
      rd_ptr_r <= accel_out_pkg::QPTR_RESET;
      count_r <= accel_out_pkg::QCOUNT_RESET;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (adv_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !adv_rd) begin
        count_r <= count_r + 1'b1; // [R9]
      end else if (do_pop && !push) begin
        count_r <= count_r - 1'b1; // [R9]
      end
    end
  end

endmodule

// ---- sim/host_reader.sv ----
// Host processor model: reads the output registers one byte at a time.
// Assumes the block answers on its read port within four cycles after the strobe.
module host_reader (
  input wire logic clk, // System clock
  input wire logic rd_valid, // Fresh answer marker from the block
  input wire logic [7:0] rd_data, // Read answer from the block
  output logic rd_en, // Read strobe, one cycle
  output logic [5:0] rd_addr // Register address of the read
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle port at time zero
  initial begin
    rd_en = 1'b0;
    rd_addr = 6'h00;
  end

  // One read; the address is scrambled once released, so a stale value is never relied on
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data, output bit ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = addr;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~addr;
    for (n = 0; n < 4; n++) begin
      if (rd_valid === 1'b1) begin
        data = rd_data;
        ok = 1'b1;
        break;
      end
      @(negedge clk);
    end
  endtask

  // Rebuilds the signed sample: sign and data bits form one two's complement word
  function automatic logic [12:0] axis_value(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo[7:3]};
  endfunction
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the accelerometer output register block.
// Assumes the host model drives the read port; the bench drives samples and modes.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset_n, sample_valid, queue_enable, queue_8bit, rd_en, rd_valid;
  logic [12:0] x_raw, y_raw, z_raw;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [15:0] lsb_w, top_w, lsb_w_n, top_w_n;
  logic [12:0] smp [3];
  logic [12:0] off [3];
  logic [5:0] lo_addr [3];
  int n_errors = 0;
  int comparisons = 0;

  accel_out_regs DUT (
    .clk(clk), .reset_n(reset_n), .sample_valid(sample_valid), .x_raw(x_raw), .y_raw(y_raw),
    .z_raw(z_raw), .queue_enable(queue_enable), .queue_8bit(queue_8bit), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .lsb_weight_ug(lsb_w),
    .top_weight_mg(top_w)
  );

  // Narrow-range variant, watched only for its weights
  accel_out_regs #(.NARROW_RANGE(1'b1)) DUT_narrow (
    .clk(clk), .reset_n(reset_n), .sample_valid(sample_valid), .x_raw(x_raw), .y_raw(y_raw),
    .z_raw(z_raw), .queue_enable(queue_enable), .queue_8bit(queue_8bit), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(), .rd_valid(), .lsb_weight_ug(lsb_w_n), .top_weight_mg(top_w_n)
  );

  host_reader host (
    .clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run, the single exit point
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A read that never answers ends the run at once
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    bit ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      n_errors++;
      $display("BAD t=%0t no answer at address %h", $time, a);
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp}, what);
  endtask

  // One sample pulse; the raw inputs are scrambled afterwards so only the pulse cycle counts
  task automatic give_sample();
    @(negedge clk);
    x_raw = smp[0];
    y_raw = smp[1];
    z_raw = smp[2];
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    x_raw = ~smp[0];
    y_raw = ~smp[1];
    z_raw = ~smp[2];
    repeat (5) @(negedge clk);
  endtask

  task automatic test_reset();
    int i;
    for (i = 4; i <= 9; i++) begin
      rd_chk(i[5:0], 8'h00, "axis byte after reset");
    end
    rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, 8'h00, "queue port after reset");
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h00, "count after reset");
    check(lsb_w, 16'h02EE, "wide lowest bit weight");
    check(top_w, 16'h0600, "wide top bit weight");
    check(lsb_w_n, 16'h01F4, "narrow lowest bit weight");
    check(top_w_n, 16'h0400, "narrow top bit weight");
    $display("test reset done");
  endtask

  // Negative, positive and most-negative-ish values exercise sign and every data bit
  task automatic test_axis();
    int i;
    logic [12:0] e;
    logic [7:0] lo, hi;
    queue_enable = 1'b0;
    smp[0] = 13'h1ABC;
    smp[1] = 13'h0543;
    smp[2] = 13'h1001;
    give_sample();
    for (i = 0; i < 3; i++) begin
      e = smp[i] + off[i];
      rd(lo_addr[i], lo);
      rd(lo_addr[i] + 6'h01, hi);
      check({8'h00, lo}, {8'h00, e[4:0], 3'h0}, "axis low byte");
      check({8'h00, hi}, {8'h00, e[12:5]}, "axis high byte");
      check({3'h0, host.axis_value(hi, lo)}, {3'h0, e}, "rebuilt axis sample");
    end
    rd_chk(6'h0A, 8'h00, "unmapped address");
    rd_chk(6'h3F, 8'h00, "unmapped address");
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h00, "count with queue off");
    $display("test axis done");
  endtask

  task automatic test_queue11();
    int i;
    logic [12:0] e;
    queue_enable = 1'b1;
    queue_8bit = 1'b0;
    smp[0] = 13'h0F3D;
    smp[1] = 13'h1C06;
    smp[2] = 13'h0FFF;
    give_sample();
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h03, "count after push");
    for (i = 0; i < 3; i++) begin
      e = smp[i] + off[i];
      rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, e[12:5], "11-bit high byte");
      rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, {e[4:2], 5'h00}, "11-bit low byte");
      rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'(2 - i), "count after entry");
    end
    rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, 8'h00, "empty queue read");
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h00, "count stays zero");
    $display("test queue 11-bit done");
  endtask

  task automatic test_queue8();
    int i;
    logic [12:0] e;
    queue_8bit = 1'b1;
    smp[0] = 13'h10A5;
    smp[1] = 13'h07E0;
    smp[2] = 13'h001F;
    give_sample();
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h03, "count after push");
    for (i = 0; i < 3; i++) begin
      e = smp[i] + off[i];
      rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, e[12:5], "8-bit byte");
    end
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'h00, "count drained");
    queue_enable = 1'b0;
    $display("test queue 8-bit done");
  endtask

  // Eleven samples overfill the ring: the oldest entry gives way and the count stops at the depth
  task automatic test_full();
    int k;
    logic [12:0] y0;
    queue_enable = 1'b1;
    smp[0] = 13'h0123;
    smp[1] = 13'h0456;
    smp[2] = 13'h0789;
    y0 = smp[1] + off[1];
    give_sample();
    smp[1] = 13'h1F00;
    for (k = 0; k < 10; k++) begin
      give_sample();
    end
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'(accel_out_pkg::QUEUE_DEPTH), "count saturates when full");
    rd_chk(accel_out_pkg::QUEUE_PORT_ADDR, y0[12:5], "oldest kept entry");
    rd_chk(accel_out_pkg::QUEUE_COUNT_ADDR, 8'(accel_out_pkg::QUEUE_DEPTH - 1), "count after read when full");
    queue_enable = 1'b0;
    $display("test queue full done");
  endtask

  // Main sequence: inputs defined at time zero, three cycles of reset, then the tests
  initial begin
    reset_n = 1'b0;
    sample_valid = 1'b0;
    queue_enable = 1'b0;
    queue_8bit = 1'b0;
    x_raw = 13'h0000;
    y_raw = 13'h0000;
    z_raw = 13'h0000;
    off[0] = accel_out_pkg::NV_X_OFFSET;
    off[1] = accel_out_pkg::NV_Y_OFFSET;
    off[2] = accel_out_pkg::NV_Z_OFFSET;
    lo_addr[0] = accel_out_pkg::X_LOW_ADDR;
    lo_addr[1] = accel_out_pkg::Y_LOW_ADDR;
    lo_addr[2] = accel_out_pkg::Z_LOW_ADDR;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_axis();
    test_queue11();
    test_queue8();
    test_full();
    stop_test();
  end
endmodule
